// [lsos_dummy_unused.sv]
// reserved for board glue; no logic lives here

// [lsos_meter_model.sv]
// metering chip model: square wave whose period the bench sets
`timescale 1ns/1ps
module lsos_meter_model (
  // clock
  input wire logic clk_sys,
  // load control from bench
  input wire logic en,
  input wire logic [15:0] period,
  // pulse to the device
  output logic pulse_out
);
  logic [15:0] cnt_q;
  logic [15:0] per_q;
  initial
  begin
    cnt_q = 16'h0000;
    per_q = 16'h0064;
    pulse_out = 1'b0;
  end
  // no load means no output toggling, line rests low
  always @(posedge clk_sys)
  begin
    if (!en)
    begin
      cnt_q <= 16'h0000;
      pulse_out <= 1'b0;
    end
    else if (cnt_q == 16'h0000)
    begin
      per_q <= period;
      cnt_q <= 16'h0001;
      pulse_out <= 1'b1;
    end
    else
    begin
      pulse_out <= (cnt_q < (per_q >> 1));
      cnt_q <= (cnt_q == per_q - 16'h0001) ? 16'h0000 : cnt_q + 16'h0001;
    end
  end
endmodule

// [lsos_pkg.sv]
// shared constants for the load sensing outlet switch
package lsos_pkg;
  localparam int unsigned CLK_HZ = 200_000_000;
  localparam int unsigned CYC_PER_MS = CLK_HZ / 1000;
  localparam int unsigned CYC_PER_US = CLK_HZ / 1_000_000;
  // start-up settling before the master outlet is powered
  localparam int unsigned INIT_CYC = 16;
  localparam int unsigned TICK_MS = 20;
  localparam int unsigned SUP_MS = 200;
  localparam int unsigned DLY_MS = 100;
  localparam int unsigned THRESH_W = 30;
  // metering chip pulse period at the power threshold; depends on the shunt, set per board
  localparam int unsigned THRESH_PERIOD_US = 1000;
  localparam int unsigned TICK_CYC = TICK_MS * CYC_PER_MS;
  localparam int unsigned DLY_CYC = DLY_MS * CYC_PER_MS;
  localparam int unsigned THRESH_CYC = THRESH_PERIOD_US * CYC_PER_US;
  localparam int unsigned SUP_TICKS = SUP_MS / TICK_MS;
  localparam int unsigned FILT_N = 6;
  localparam int unsigned IVAL_W = 32;
endpackage

// [lsos_smp_if.sv]
// interval samples into the trimmed-mean filter and its result back
`timescale 1ns/1ps
interface lsos_smp_if #(parameter int W = 32);
  logic smp_vld;
  logic [W-1:0] smp;
  logic flush;
  logic filt_vld;
  logic [W-1:0] filt;
  modport src (output smp_vld, output smp, output flush, input filt_vld, input filt);
  modport flt (input smp_vld, input smp, input flush, output filt_vld, output filt);
endinterface

// [lsos_tmean.sv]
// trimmed-mean filter: drops smallest and largest of a window, averages the rest
`timescale 1ns/1ps
module lsos_tmean #(
  parameter int N = lsos_pkg::FILT_N,
  parameter int W = lsos_pkg::IVAL_W
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic arst_n,
  // samples in, result out
  lsos_smp_if.flt ifc
);
  localparam int FW = $clog2(N + 1);
  localparam int SW = W + $clog2(N) + 1;
  typedef struct packed {
    logic [N-1:0][W-1:0] win;
    logic [FW-1:0] fill;
    logic upd;
    logic vld;
    logic [W-1:0] res;
  } lsos_tm_st_t;
  lsos_tm_st_t s_q;
  lsos_tm_st_t s_d;
  logic [SW-1:0] sum;
  logic [W-1:0] mn;
  logic [W-1:0] mx;

  assign ifc.filt_vld = s_q.vld;
  assign ifc.filt = s_q.res;

  always_comb
  begin
    s_d = s_q;
    sum = '0;
    mn = s_q.win[0];
    mx = s_q.win[0];
    for (int i = 0; i < N; i++)
    begin
      sum = sum + SW'(s_q.win[i]);
      if (s_q.win[i] < mn)
        mn = s_q.win[i];
      if (s_q.win[i] > mx)
        mx = s_q.win[i];
    end
    s_d.upd = 1'b0;
    // result only once the window is full, so start-up zeros never count
    if (s_q.upd && s_q.fill == FW'(N))
    begin
      s_d.vld = 1'b1;
      s_d.res = W'((sum - SW'(mn) - SW'(mx)) / SW'(N - 2));
    end
    if (ifc.flush)
    begin
      s_d.fill = '0;
      s_d.vld = 1'b0;
    end
    else if (ifc.smp_vld)
    begin
      s_d.win = {s_q.win[N-2:0], ifc.smp};
      s_d.fill = (s_q.fill == FW'(N)) ? s_q.fill : s_q.fill + FW'(1);
      s_d.upd = 1'b1;
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
      s_q <= '0;
    else
      s_q <= s_d;
  end

  property p_filt_trim;
    @(posedge clk_sys) disable iff (!arst_n)
    (s_q.upd && s_q.fill == FW'(N) && !ifc.flush) |=> (s_q.vld && s_q.res >= $past(mn) && s_q.res <= $past(mx));
  endproperty
  a_filt_trim: assert property (p_filt_trim) else $error("filter result outside trimmed range");

  property p_filt_flush;
    @(posedge clk_sys) disable iff (!arst_n)
    ifc.flush |=> !s_q.vld && s_q.fill == '0;
  endproperty
  a_filt_flush: assert property (p_filt_flush) else $error("filter not cleared by flush");
endmodule

// [lsos_top.sv]
// load sensing outlet switch: pulse interval capture, filtering, supervision, relay drive
`timescale 1ns/1ps
module lsos_top #(
  parameter int unsigned TICK_CYC = lsos_pkg::TICK_CYC,
  parameter int unsigned DLY_CYC = lsos_pkg::DLY_CYC,
  parameter int unsigned THRESH_CYC = lsos_pkg::THRESH_CYC
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic arst_n,
  // metering chip pulse
  input wire logic power_pulse_in,
  // relays
  output logic master_relay_out,
  output logic slave_relay_out,
  // status
  output logic no_load_out
);
  localparam int IW = lsos_pkg::IVAL_W;
  localparam int CW = 32;
  localparam int SPW = 4;
  localparam logic [CW-1:0] INIT_LAST = CW'(lsos_pkg::INIT_CYC - 1);
  localparam logic [CW-1:0] TICK_LAST = CW'(TICK_CYC - 1);
  localparam logic [CW-1:0] DLY_LAST = CW'(DLY_CYC - 1);
  localparam logic [IW-1:0] THRESH_IV = IW'(THRESH_CYC);
  localparam logic [SPW-1:0] SUP_LAST = SPW'(lsos_pkg::SUP_TICKS - 1);

  typedef enum logic [1:0] {ST_INIT, ST_RUN} lsos_st_t;
  typedef struct packed {
    lsos_st_t st;
    logic [CW-1:0] init_cnt;
    logic [1:0] sync;
    logic prev;
    logic seen;
    logic [IW-1:0] ival;
    logic smp_vld;
    logic [IW-1:0] smp;
    logic flush;
    logic [CW-1:0] tick_cnt;
    logic tick;
    logic [SPW-1:0] sup_cnt;
    logic timeout;
    logic [CW-1:0] dly_cnt;
    logic master;
    logic slave;
  } lsos_top_st_t;

  lsos_top_st_t s_q;
  lsos_top_st_t s_d;
  logic rise;
  logic want_on;

  lsos_smp_if #(.W(IW)) smp_if ();

  lsos_tmean #(
    .N(lsos_pkg::FILT_N),
    .W(IW)
  ) u_tmean (
    .clk_sys(clk_sys),
    .arst_n(arst_n),
    .ifc(smp_if.flt)
  );

  assign smp_if.smp_vld = s_q.smp_vld;
  assign smp_if.smp = s_q.smp;
  assign smp_if.flush = s_q.flush;
  assign master_relay_out = s_q.master;
  assign slave_relay_out = s_q.slave;
  assign no_load_out = s_q.timeout;

  // sync[0] is the first stage, only sync[1] is looked at
  assign rise = s_q.sync[1] & ~s_q.prev;
  // pulse frequency tracks power, so a short period is a heavy load
  assign want_on = !s_q.timeout && smp_if.filt_vld && (smp_if.filt < THRESH_IV);

  always_comb
  begin
    s_d = s_q;
    s_d.sync = {s_q.sync[0], power_pulse_in};
    s_d.prev = s_q.sync[1];
    s_d.smp_vld = 1'b0;
    s_d.flush = 1'b0;
    s_d.tick = 1'b0;
    case (s_q.st)
      ST_INIT:
      begin
        s_d.init_cnt = s_q.init_cnt + CW'(1);
        if (s_q.init_cnt == INIT_LAST)
        begin
          s_d.st = ST_RUN;
          s_d.master = 1'b1;
        end
      end
      ST_RUN:
      begin
        // saturate so a very slow train still reads as a long interval
        if (s_q.ival != '1)
          s_d.ival = s_q.ival + IW'(1);
        if (s_q.tick_cnt == TICK_LAST)
        begin
          s_d.tick_cnt = '0;
          s_d.tick = 1'b1;
        end
        else
          s_d.tick_cnt = s_q.tick_cnt + CW'(1);
        if (s_q.tick && !s_q.timeout)
        begin
          if (s_q.sup_cnt == SUP_LAST)
          begin
            s_d.timeout = 1'b1;
            s_d.flush = 1'b1;
          end
          else
            s_d.sup_cnt = s_q.sup_cnt + SPW'(1);
        end
        // a pulse restarts supervision; it wins over a tick in the same cycle
        if (rise)
        begin
          // the edge cycle counts too, so a period of p cycles reads as p
          s_d.ival = IW'(1);
          s_d.seen = 1'b1;
          s_d.sup_cnt = '0;
          s_d.timeout = 1'b0;
          s_d.flush = 1'b0;
          if (s_q.seen && !s_q.timeout)
          begin
            s_d.smp_vld = 1'b1;
            s_d.smp = s_q.ival;
          end
        end
        // a change must persist for the whole delay; a glitch restarts it
        if (want_on != s_q.slave)
        begin
          if (s_q.dly_cnt == DLY_LAST)
          begin
            s_d.dly_cnt = '0;
            s_d.slave = want_on;
          end
          else
            s_d.dly_cnt = s_q.dly_cnt + CW'(1);
        end
        else
          s_d.dly_cnt = '0;
      end
      default:
      begin
        s_d = '0;
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
      s_q <= '0;
    else
      s_q <= s_d;
  end

  property p_master_hold;
    @(posedge clk_sys) disable iff (!arst_n)
    master_relay_out |=> master_relay_out;
  endproperty
  a_master_hold: assert property (p_master_hold) else $error("master relay dropped");

  property p_master_init;
    @(posedge clk_sys) disable iff (!arst_n)
    (s_q.st == ST_INIT && s_q.init_cnt == INIT_LAST) |=> master_relay_out && s_q.st == ST_RUN;
  endproperty
  a_master_init: assert property (p_master_init) else $error("master relay not on after init");

  property p_capture;
    @(posedge clk_sys) disable iff (!arst_n)
    (s_q.st == ST_RUN && rise && s_q.seen && !s_q.timeout) |=>
      (s_q.smp_vld && s_q.smp == $past(s_q.ival) && s_q.ival == IW'(1));
  endproperty
  a_capture: assert property (p_capture) else $error("pulse interval not captured");

  property p_sync_path;
    @(posedge clk_sys) disable iff (!arst_n)
    $rose(power_pulse_in) ##1 power_pulse_in |=> s_q.sync[1];
  endproperty
  a_sync_path: assert property (p_sync_path) else $error("pulse input not seen after two stages");

  property p_tick_period;
    @(posedge clk_sys) disable iff (!arst_n)
    s_q.tick |-> $past(s_q.tick_cnt) == TICK_LAST && s_q.tick_cnt == '0;
  endproperty
  a_tick_period: assert property (p_tick_period) else $error("supervision tick off period");

  property p_timeout;
    @(posedge clk_sys) disable iff (!arst_n)
    (s_q.tick && !s_q.timeout && s_q.sup_cnt == SUP_LAST && !rise) |=> no_load_out ##1 !smp_if.filt_vld;
  endproperty
  a_timeout: assert property (p_timeout) else $error("no-load timeout not raised");

  property p_slave_on;
    @(posedge clk_sys) disable iff (!arst_n)
    $rose(slave_relay_out) |-> $past(want_on) && $past(s_q.dly_cnt) == DLY_LAST;
  endproperty
  a_slave_on: assert property (p_slave_on) else $error("slave on without full delay");

  property p_slave_off;
    @(posedge clk_sys) disable iff (!arst_n)
    $fell(slave_relay_out) |-> !$past(want_on) && $past(s_q.dly_cnt) == DLY_LAST;
  endproperty
  a_slave_off: assert property (p_slave_off) else $error("slave off without full delay");

  property p_slave_steady;
    @(posedge clk_sys) disable iff (!arst_n)
    (want_on == slave_relay_out) |=> $stable(slave_relay_out);
  endproperty
  a_slave_steady: assert property (p_slave_steady) else $error("slave relay changed with no cause");

  c_slave_on: cover property (@(posedge clk_sys) disable iff (!arst_n) $rose(slave_relay_out));
  c_slave_off: cover property (@(posedge clk_sys) disable iff (!arst_n) $fell(slave_relay_out));
  c_timeout: cover property (@(posedge clk_sys) disable iff (!arst_n) $rose(no_load_out));
  c_filt: cover property (@(posedge clk_sys) disable iff (!arst_n) $rose(smp_if.filt_vld));
endmodule

// [lsos_top_tb_top.sv]
// self-checking bench for the load sensing outlet switch
`timescale 1ns/1ps
module lsos_top_tb_top;
  localparam int TICK = 50;
  localparam int DLY = 40;
  localparam int THR = 100;
  logic clk_sys;
  logic arst_n;
  logic mod_en;
  logic [15:0] mod_per;
  logic pulse;
  logic master_relay_out;
  logic slave_relay_out;
  logic no_load_out;
  int err_count;
  int check_count;
  int cyc;
  int n;
  lsos_meter_model meter (.clk_sys(clk_sys), .en(mod_en), .period(mod_per), .pulse_out(pulse));
  lsos_top #(.TICK_CYC(TICK), .DLY_CYC(DLY), .THRESH_CYC(THR)) uut (
    .clk_sys(clk_sys), .arst_n(arst_n), .power_pulse_in(pulse), .master_relay_out(master_relay_out),
    .slave_relay_out(slave_relay_out), .no_load_out(no_load_out));
  initial
  begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    check_count++;
    if (seen !== exp)
    begin
      err_count++;
      $display("BAD t=%0t %s seen %0h exp %0h", $time, msg, seen, exp);
    end
  endtask
  task automatic wait_sig(input bit sel, input logic val, input int lim, output int k);
    k = 0;
    while (((sel ? no_load_out : slave_relay_out) !== val) && k < lim)
    begin
      @(posedge clk_sys);
      #1;
      k++;
    end
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic t_init();
    arst_n <= 1'b1;
    repeat (15) @(posedge clk_sys);
    #1;
    chk(master_relay_out, 1'b0, "master early");
    @(posedge clk_sys);
    #1;
    chk(master_relay_out, 1'b1, "master on");
    chk(slave_relay_out, 1'b0, "slave at start");
    $display("init done");
  endtask
  task automatic t_heavy();
    @(posedge clk_sys);
    mod_per <= 16'h0028;
    mod_en <= 1'b1;
    wait_sig(1'b0, 1'b1, 2000, n);
    chk(slave_relay_out, 1'b1, "slave on heavy");
    chk(n >= 6 * 40 + DLY, 1'b1, "slave on too early");
    chk(n <= 7 * 40 + DLY + 10, 1'b1, "slave on too late");
    $display("heavy done");
  endtask
  task automatic t_outlier();
    int drops;
    drops = 0;
    @(posedge pulse);
    mod_per <= 16'h0190;
    @(posedge pulse);
    mod_per <= 16'h0028;
    repeat (6 * 40 + 400 + DLY + 20)
    begin
      @(posedge clk_sys);
      #1;
      if (slave_relay_out !== 1'b1)
        drops++;
    end
    chk(drops, 0, "outlier not trimmed");
    $display("outlier done");
  endtask
  task automatic t_light();
    @(posedge clk_sys);
    mod_per <= 16'h00c8;
    wait_sig(1'b0, 1'b0, 3000, n);
    chk(slave_relay_out, 1'b0, "slave off light");
    chk(n >= DLY, 1'b1, "slave off too early");
    $display("light done");
  endtask
  task automatic t_equal();
    int rises;
    rises = 0;
    @(posedge clk_sys);
    mod_per <= 16'(THR);
    repeat (1000)
    begin
      @(posedge clk_sys);
      #1;
      if (slave_relay_out !== 1'b0)
        rises++;
    end
    chk(rises, 0, "equal interval turned slave on");
    $display("equal done");
  endtask
  task automatic t_noload();
    @(posedge clk_sys);
    mod_per <= 16'h0028;
    wait_sig(1'b0, 1'b1, 2000, n);
    chk(slave_relay_out, 1'b1, "slave on before silence");
    @(posedge clk_sys);
    mod_en <= 1'b0;
    repeat (8 * TICK) @(posedge clk_sys);
    #1;
    chk(no_load_out, 1'b0, "no load too early");
    wait_sig(1'b1, 1'b1, 3 * TICK, n);
    chk(no_load_out, 1'b1, "no load missing");
    chk(slave_relay_out, 1'b1, "slave off without delay");
    wait_sig(1'b0, 1'b0, DLY + 5, n);
    chk(slave_relay_out, 1'b0, "slave off after no load");
    chk(n >= DLY - 2, 1'b1, "no load delay short");
    @(posedge clk_sys);
    mod_en <= 1'b1;
    wait_sig(1'b1, 1'b0, 20, n);
    chk(n <= 5, 1'b1, "pulse edge did not clear no load");
    chk(master_relay_out, 1'b1, "master stays on");
    $display("noload done");
  endtask
  always @(posedge clk_sys)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      err_count++;
      $display("BAD t=%0t run timed out", $time);
      wrap_up();
    end
  end
  initial
  begin
    err_count = 0;
    check_count = 0;
    cyc = 0;
    arst_n = 1'b0;
    mod_en = 1'b0;
    mod_per = 16'h0028;
    repeat (5) @(posedge clk_sys);
    t_init();
    t_heavy();
    t_outlier();
    t_light();
    t_equal();
    t_noload();
    wrap_up();
  end
endmodule
